// *** verilog/pswin_cfg.svh ***
// Constants for the setpoint, feedback and window block
`ifndef PSWIN_CFG_SVH
`define PSWIN_CFG_SVH

// ==========================================================
// Count scale
`define PSW_CNT_FS 13'h0FFF
`define PSW_CNT_MAX 13'h1332
`define PSW_CNT_FS_MUL 16'h0FFF
`define PSW_WORD_CNT_HI 12

// ==========================================================
// Reset values
`define PSW_GAIN_DEF 4'h8
`define PSW_SENS_DEF 3'h2

// ==========================================================
// Window timing: clock and tick in ns, timeout in tenths of a second
`define PSW_CLK_NS 5
`define PSW_TICK_NS 100000000
`define PSW_TMO_MAX_DS 8'h64
`define PSW_TMO_STEP_DS 8'h06

// ==========================================================
// Window half width: counts = (BASE + STEP * sens) * FS / DEN
`define PSW_WIN_BASE 16'h0007
`define PSW_WIN_STEP 16'h0004
`define PSW_WIN_DEN 28'h00002BC

// ==========================================================
// Full scale in scaled units (100% value times multiplier)
`define PSW_FS_B01_MPA 16'h2710
`define PSW_FS_B01_KG 16'h27D5
`define PSW_FS_B01_BAR 16'h2710
`define PSW_FS_B01_PSI 16'h38A8
`define PSW_FS_B01_KPA 16'h2710
`define PSW_FS_B05_MPA 16'hC350
`define PSW_FS_B05_KG 16'hC72A
`define PSW_FS_B05_BAR 16'hC350
`define PSW_FS_B05_PSI 16'h1C54
`define PSW_FS_B05_KPA 16'hC350
`define PSW_FS_B09_MPA 16'h2328
`define PSW_FS_B09_KG 16'h23DA
`define PSW_FS_B09_BAR 16'h2328
`define PSW_FS_B09_PSI 16'h32FD
`define PSW_FS_B09_KPA 16'h2328
`define PSW_FS_VAC_MPA 16'h1F40
`define PSW_FS_VAC_KG 16'h1FDE
`define PSW_FS_VAC_BAR 16'h1F40
`define PSW_FS_VAC_PSI 16'h2D53
`define PSW_FS_VAC_KPA 16'h1F40

`endif

// *** verilog/pswin_pkg.sv ***
// Types for the setpoint, feedback and window block
package pswin_pkg;
   typedef enum logic [2:0] {
      U_CNT = 3'h0,
      U_KGCM2 = 3'h1,
      U_BAR = 3'h2,
      U_PSI = 3'h3,
      U_KPA = 3'h4,
      U_MPA = 3'h5
   } unit_t;

   typedef enum logic [1:0] {
      B_01 = 2'h0,
      B_05 = 2'h1,
      B_09 = 2'h2,
      B_VAC = 2'h3
   } body_t;

   typedef enum logic [1:0] {
      W_IN = 2'h0,
      W_OUT = 2'h1,
      W_FAULT = 2'h3
   } win_state_t;
endpackage

// *** verilog/scale_if.sv ***
// Carrier between the top and the unit scaler
`timescale 1ns/1ps
interface scale_if;
   import pswin_pkg::*;
   unit_t unit;
   body_t body;
   logic [15:0] sp_word;
   logic [12:0] fb_count;
   logic [15:0] sp_scaled;
   logic [15:0] fb_scaled;

   modport scaler (input unit, input body, input sp_word, input fb_count,
      output sp_scaled, output fb_scaled);
   modport user (output unit, output body, output sp_word, output fb_count,
      input sp_scaled, input fb_scaled);
endinterface

// *** verilog/unit_scaler.sv ***
// Conversion between counts and scaled engineering units
`timescale 1ns/1ps
`include "pswin_cfg.svh"
module unit_scaler
   import pswin_pkg::*;
(
   scale_if.scaler s
);
   logic [15:0] fs_eng;
   logic [27:0] sp_prod;
   logic [27:0] sp_quot;
   logic [28:0] fb_prod;
   logic [28:0] fb_quot;

   // ==========================================================
   // Full scale per body and unit
   // body range multipliers
   always_comb begin
      case ({s.body, s.unit})
         {B_01, U_MPA}: fs_eng = `PSW_FS_B01_MPA;
         {B_01, U_KGCM2}: fs_eng = `PSW_FS_B01_KG;
         {B_01, U_BAR}: fs_eng = `PSW_FS_B01_BAR;
         {B_01, U_PSI}: fs_eng = `PSW_FS_B01_PSI;
         {B_01, U_KPA}: fs_eng = `PSW_FS_B01_KPA;
         {B_05, U_MPA}: fs_eng = `PSW_FS_B05_MPA;
         {B_05, U_KGCM2}: fs_eng = `PSW_FS_B05_KG;
         {B_05, U_BAR}: fs_eng = `PSW_FS_B05_BAR;
         {B_05, U_PSI}: fs_eng = `PSW_FS_B05_PSI;
         {B_05, U_KPA}: fs_eng = `PSW_FS_B05_KPA;
         {B_09, U_MPA}: fs_eng = `PSW_FS_B09_MPA;
         {B_09, U_KGCM2}: fs_eng = `PSW_FS_B09_KG;
         {B_09, U_BAR}: fs_eng = `PSW_FS_B09_BAR;
         {B_09, U_PSI}: fs_eng = `PSW_FS_B09_PSI;
         {B_09, U_KPA}: fs_eng = `PSW_FS_B09_KPA;
         {B_VAC, U_MPA}: fs_eng = `PSW_FS_VAC_MPA;
         {B_VAC, U_KGCM2}: fs_eng = `PSW_FS_VAC_KG;
         {B_VAC, U_BAR}: fs_eng = `PSW_FS_VAC_BAR;
         {B_VAC, U_PSI}: fs_eng = `PSW_FS_VAC_PSI;
         {B_VAC, U_KPA}: fs_eng = `PSW_FS_VAC_KPA;
         default: fs_eng = `PSW_CNT_FS_MUL;
      endcase
   end

   // ==========================================================
   // Setpoint to counts, counts to feedback
   // scaled setpoint to counts
   assign sp_prod = 28'(s.sp_word) * 28'(`PSW_CNT_FS_MUL);
   assign sp_quot = sp_prod / 28'(fs_eng);
   assign fb_prod = 29'(s.fb_count) * 29'(fs_eng);
   assign fb_quot = fb_prod / 29'(`PSW_CNT_FS_MUL);
   assign s.sp_scaled = (sp_quot[27:16] != 12'h000) ? 16'hFFFF : sp_quot[15:0];
   assign s.fb_scaled = (fb_quot[28:16] != 13'h0000) ? 16'hFFFF : fb_quot[15:0];
endmodule // unit_scaler

// *** verilog/window_mon.sv ***
// In-range window diagnostic
`timescale 1ns/1ps
`include "pswin_cfg.svh"
module window_mon
   import pswin_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic [12:0] sp_count,
   input wire logic [12:0] fb_count,
   input wire logic [3:0] gain,
   input wire logic [2:0] sens,
   output logic fault
);
   win_state_t state_reg;
   win_state_t state_next;
   logic [7:0] elapsed_reg;
   logic [7:0] elapsed_next;
   logic [7:0] timeout_ds;
   logic [27:0] half_prod;
   logic [12:0] half_width;
   logic [12:0] diff;
   logic outside;
   logic expired;

   // ==========================================================
   // Window width and timeout
   // half width from deadband
   assign half_prod = 28'(`PSW_WIN_BASE + `PSW_WIN_STEP * 16'(sens)) * 28'(`PSW_CNT_FS_MUL);
   assign half_width = 13'(half_prod / `PSW_WIN_DEN);
   assign timeout_ds = `PSW_TMO_MAX_DS - `PSW_TMO_STEP_DS * 8'(gain);
   assign diff = (fb_count > sp_count) ? fb_count - sp_count : sp_count - fb_count;
   assign outside = diff > half_width;
   assign expired = tick && (elapsed_reg + 8'h01 >= timeout_ds);

   // ==========================================================
   // Window state
   // set after timeout, clear inside
   always_comb begin
      state_next = state_reg;
      elapsed_next = elapsed_reg;
      case (state_reg)
         W_IN: begin
            elapsed_next = 8'h00;
            if (outside) state_next = W_OUT;
         end
         W_OUT: begin
            if (!outside) begin
               state_next = W_IN;
               elapsed_next = 8'h00;
            end else if (expired) begin
               state_next = W_FAULT;
            end else if (tick) begin
               elapsed_next = elapsed_reg + 8'h01;
            end
         end
         W_FAULT: begin
            if (!outside) state_next = W_IN;
            elapsed_next = 8'h00;
         end
         default: begin
            state_next = W_IN;
            elapsed_next = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= W_IN;
         elapsed_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         elapsed_reg <= elapsed_next;
      end
   end

   assign fault = (state_reg == W_FAULT);

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   fault_clear_a: assert property (!outside |=> !fault)
      else $error("window fault stayed with feedback inside");
   fault_set_a: assert property (state_reg == W_OUT && outside && expired |=> fault)
      else $error("window fault missing after timeout");
   fault_cause_a: assert property ($rose(fault) |-> $past(outside) && $past(tick))
      else $error("window fault rose without timeout tick");
   fault_seen_c: cover property (state_reg == W_OUT ##1 fault [*2] ##1 !fault);
endmodule // window_mon

// *** verilog/pswin_top.sv ***
// Setpoint, feedback and in-range window diagnostic top
`timescale 1ns/1ps
`include "pswin_cfg.svh"
module pswin_top
   import pswin_pkg::*;
#(
   parameter int TICK_CYCLES = `PSW_TICK_NS / `PSW_CLK_NS
)
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [15:0] SETPOINT_WORD,
   input wire logic [12:0] FEEDBACK_COUNT,
   input wire logic [1:0] BODY_SEL,
   input wire logic [2:0] UNIT_SEL,
   input wire logic UNIT_WR,
   input wire logic NV_LOAD,
   input wire logic [2:0] NV_UNIT,
   input wire logic [3:0] GAIN_IN,
   input wire logic GAIN_WR,
   input wire logic [2:0] SENS_IN,
   input wire logic SENS_WR,
   output logic [12:0] SETPOINT_COUNT,
   output logic [15:0] FEEDBACK_WORD,
   output logic WINDOW_FAULT,
   output logic [2:0] UNIT_ACTIVE,
   output logic [3:0] GAIN_ACTIVE,
   output logic [2:0] SENS_ACTIVE,
   output logic NV_WR,
   output logic [2:0] NV_WR_UNIT
);
   unit_t unit_reg;
   unit_t unit_next;
   logic [3:0] gain_reg;
   logic [2:0] sens_reg;
   logic [12:0] sp_reg;
   logic [12:0] sp_next;
   logic [15:0] fb_reg;
   logic [15:0] fb_next;
   logic nv_wr_reg;
   logic [31:0] div_reg;
   logic tick;
   logic [12:0] sp_limit;
   logic [15:0] sp_raw;
   logic sp_over;
   logic [12:0] fb_clip;
   logic unit_ok;
   logic nv_ok;
   scale_if sif ();

   // ==========================================================
   // Unit scaler
   assign sif.unit = unit_reg;
   assign sif.body = body_t'(BODY_SEL);
   assign sif.sp_word = SETPOINT_WORD;
   assign sif.fb_count = fb_clip;

   unit_scaler u_scaler (
      .s(sif.scaler)
   );

   // ==========================================================
   // Settings
   assign unit_ok = (UNIT_SEL <= U_MPA);
   assign nv_ok = (NV_UNIT <= U_MPA);

   always_comb begin
      unit_next = unit_reg;
      if (UNIT_WR && unit_ok) unit_next = unit_t'(UNIT_SEL);
      else if (NV_LOAD && nv_ok) unit_next = unit_t'(NV_UNIT);
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) unit_reg <= U_CNT;
      else unit_reg <= unit_next;
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) gain_reg <= `PSW_GAIN_DEF;
      else if (GAIN_WR) gain_reg <= GAIN_IN;
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) sens_reg <= `PSW_SENS_DEF;
      else if (SENS_WR) sens_reg <= SENS_IN;
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) nv_wr_reg <= 1'b0;
      else nv_wr_reg <= UNIT_WR && unit_ok;
   end

   // ==========================================================
   // Setpoint path
   // vacuum limit
   assign sp_limit = (body_t'(BODY_SEL) == B_VAC) ? `PSW_CNT_FS : `PSW_CNT_MAX;
   assign sp_raw = (unit_reg == U_CNT) ? {3'h0, SETPOINT_WORD[`PSW_WORD_CNT_HI:0]} :
      sif.sp_scaled;
   assign sp_over = sp_raw > {3'h0, sp_limit};
   assign sp_next = sp_over ? sp_limit : sp_raw[12:0];

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) sp_reg <= 13'h0000;
      else sp_reg <= sp_next;
   end

   // ==========================================================
   // Feedback path
   assign fb_clip = (FEEDBACK_COUNT > `PSW_CNT_MAX) ? `PSW_CNT_MAX : FEEDBACK_COUNT;
   assign fb_next = (unit_reg == U_CNT) ? {3'h0, fb_clip} : sif.fb_scaled;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) fb_reg <= 16'h0000;
      else fb_reg <= fb_next;
   end

   // ==========================================================
   // Tenth-second tick
   assign tick = (div_reg == 32'(TICK_CYCLES - 1));

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) div_reg <= 32'h00000000;
      else if (tick) div_reg <= 32'h00000000;
      else div_reg <= div_reg + 32'h00000001;
   end

   // ==========================================================
   // Window diagnostic
   // no enable
   window_mon u_window (
      .clk(CLK),
      .rst_n(RSTN),
      .tick(tick),
      .sp_count(sp_reg),
      .fb_count(fb_clip),
      .gain(gain_reg),
      .sens(sens_reg),
      .fault(WINDOW_FAULT)
   );

   // ==========================================================
   // Outputs
   assign SETPOINT_COUNT = sp_reg;
   assign FEEDBACK_WORD = fb_reg;
   assign UNIT_ACTIVE = unit_reg;
   assign GAIN_ACTIVE = gain_reg;
   assign SENS_ACTIVE = sens_reg;
   assign NV_WR = nv_wr_reg;
   assign NV_WR_UNIT = unit_reg;

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   gain_default_a: assert property ($rose(RSTN) |-> gain_reg == `PSW_GAIN_DEF)
      else $error("gain not at default after reset");
   sens_default_a: assert property ($rose(RSTN) |-> sens_reg == `PSW_SENS_DEF)
      else $error("deadband not at default after reset");
   unit_default_a: assert property ($rose(RSTN) |-> unit_reg == U_CNT)
      else $error("unit not counts after reset");
   unit_write_a: assert property (UNIT_WR && unit_ok |=> unit_reg == $past(UNIT_SEL) && NV_WR)
      else $error("unit write not applied or not stored");
   sp_limit_a: assert property (SETPOINT_COUNT <= `PSW_CNT_MAX)
      else $error("setpoint above over-range limit");
   vac_limit_a: assert property (BODY_SEL == B_VAC && $stable(BODY_SEL) |=> SETPOINT_COUNT <= `PSW_CNT_FS)
      else $error("vacuum setpoint beyond full scale");
   sp_count_a: assert property (unit_reg == U_CNT && SETPOINT_WORD[12:0] <= sp_limit |=> SETPOINT_COUNT == $past(SETPOINT_WORD[12:0]))
      else $error("count setpoint not passed through");
   sp_sat_a: assert property (unit_reg == U_CNT && SETPOINT_WORD[12:0] > sp_limit |=> SETPOINT_COUNT == $past(sp_limit))
      else $error("setpoint not saturated");
   fb_count_a: assert property (unit_reg == U_CNT && FEEDBACK_COUNT <= `PSW_CNT_FS |=> FEEDBACK_WORD[15:12] == 4'h0 && FEEDBACK_WORD[11:0] == $past(FEEDBACK_COUNT[11:0]))
      else $error("count feedback malformed");
   tick_period_a: assert property (tick |=> !tick)
      else $error("tick longer than one cycle");

   unit_change_c: cover property (UNIT_WR ##1 unit_reg != U_CNT);
   over_range_c: cover property (SETPOINT_COUNT == `PSW_CNT_MAX);
   fault_c: cover property ($rose(WINDOW_FAULT));
endmodule // pswin_top

// *** tb/plc_master.sv ***
// Model of the master that sends setpoints and reads feedback
`timescale 1ns/1ps
module plc_master (
   input wire logic clk,
   input wire logic [15:0] feedback_word,
   output logic [15:0] setpoint_word
);
   logic [15:0] seen_feedback;

   initial begin
      setpoint_word = 16'h0000;
   end

   // ==========================================================
   // Setpoint word
   // rounded integer word
   task automatic send(input logic [15:0] w);
      @(posedge clk);
      setpoint_word <= w;
   endtask

   // ==========================================================
   // Feedback capture
   // word read every cycle
   always @(posedge clk) begin
      seen_feedback <= feedback_word;
   end
endmodule // plc_master

// *** tb/pswin_top_tb.sv ***
// Self-checking bench for the setpoint, feedback and window block
`timescale 1ns/1ps
`include "pswin_cfg.svh"
module pswin_top_tb;
   import pswin_pkg::*;
   logic clk;
   logic rstn;
   logic [15:0] sp_word;
   logic [12:0] fb_count;
   logic [1:0] body_sel;
   logic [2:0] unit_sel;
   logic unit_wr;
   logic nv_load;
   logic [2:0] nv_unit;
   logic [3:0] gain_in;
   logic gain_wr;
   logic [2:0] sens_in;
   logic sens_wr;
   logic [12:0] sp_count;
   logic [15:0] fb_word;
   logic win_fault;
   logic [2:0] unit_act;
   logic [3:0] gain_act;
   logic [2:0] sens_act;
   logic nv_wr;
   logic [2:0] nv_wr_unit;
   logic [15:0] fs01 [1:5];
   int bad_count;
   int tests_run;
   int u;

   // ==========================================================
   // Instances
   plc_master plc (.clk(clk), .feedback_word(fb_word), .setpoint_word(sp_word));

   pswin_top #(.TICK_CYCLES(10)) uut (
      .CLK(clk), .RSTN(rstn), .SETPOINT_WORD(sp_word), .FEEDBACK_COUNT(fb_count),
      .BODY_SEL(body_sel), .UNIT_SEL(unit_sel), .UNIT_WR(unit_wr), .NV_LOAD(nv_load),
      .NV_UNIT(nv_unit), .GAIN_IN(gain_in), .GAIN_WR(gain_wr), .SENS_IN(sens_in),
      .SENS_WR(sens_wr), .SETPOINT_COUNT(sp_count), .FEEDBACK_WORD(fb_word),
      .WINDOW_FAULT(win_fault), .UNIT_ACTIVE(unit_act), .GAIN_ACTIVE(gain_act),
      .SENS_ACTIVE(sens_act), .NV_WR(nv_wr), .NV_WR_UNIT(nv_wr_unit));

   // ==========================================================
   // Tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic set_unit(input logic [2:0] v);
      @(posedge clk);
      unit_sel <= v;
      unit_wr <= 1'b1;
      @(posedge clk);
      unit_wr <= 1'b0;
      #1;
   endtask

   task automatic set_gs(input logic [3:0] g, input logic [2:0] s, input logic w = 1'b1);
      @(posedge clk);
      gain_in <= g;
      sens_in <= s;
      gain_wr <= w;
      sens_wr <= w;
      @(posedge clk);
      gain_wr <= 1'b0;
      sens_wr <= 1'b0;
   endtask

   task automatic restore(input logic [2:0] v, input logic ld);
      @(posedge clk);
      nv_unit <= v;
      nv_load <= ld;
      @(posedge clk);
      nv_load <= 1'b0;
      wt(1);
   endtask

   task automatic drive(input logic [12:0] fb, input logic [1:0] b);
      @(posedge clk);
      fb_count <= fb;
      body_sel <= b;
   endtask

   task automatic expect_fault(input int quiet, input int lim);
      int c;
      wt(quiet);
      chk({15'h0, win_fault}, 16'h0000);
      c = 0;
      while (win_fault !== 1'b1 && c < lim) begin
         wt(1);
         c++;
      end
      chk({15'h0, win_fault}, 16'h0001);
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      #100000;
      bad_count++;
      conclude();
   end

   // ==========================================================
   // Tests
   initial begin
      bad_count = 0;
      tests_run = 0;
      rstn = 1'b0;
      fb_count = 13'h0000;
      body_sel = 2'h0;
      unit_sel = 3'h0;
      unit_wr = 1'b0;
      nv_load = 1'b0;
      nv_unit = 3'h0;
      gain_in = 4'h0;
      gain_wr = 1'b0;
      sens_in = 3'h0;
      sens_wr = 1'b0;
      fs01[1] = `PSW_FS_B01_KG;
      fs01[2] = `PSW_FS_B01_BAR;
      fs01[3] = `PSW_FS_B01_PSI;
      fs01[4] = `PSW_FS_B01_KPA;
      fs01[5] = `PSW_FS_B01_MPA;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      wt(1);
      chk({12'h0, gain_act}, 16'h0008);
      chk({13'h0, sens_act}, 16'h0002);
      chk({13'h0, unit_act}, 16'h0000);
      // Count mode words and over-range
      plc.send(16'hE800);
      drive(13'h0FFF, B_01);
      wt(3);
      chk({3'h0, sp_count}, 16'h0800);
      chk(fb_word, 16'h0FFF);
      plc.send(16'h1332);
      drive(13'h1332, B_01);
      wt(3);
      chk({3'h0, sp_count}, 16'h1332);
      chk(fb_word, 16'h1332);
      plc.send(16'h1FFF);
      wt(3);
      chk({3'h0, sp_count}, 16'h1332);
      drive(13'h0FFF, B_VAC);
      plc.send(16'h1332);
      wt(3);
      chk({3'h0, sp_count}, 16'h0FFF);
      // Unit change reinterprets the held setpoint
      plc.send(16'h0800);
      drive(13'h0FFF, B_01);
      wt(3);
      set_unit(U_KPA);
      chk({15'h0, nv_wr}, 16'h0001);
      chk({13'h0, nv_wr_unit}, 16'h0004);
      chk({13'h0, unit_act}, 16'h0004);
      wt(2);
      chk({15'h0, nv_wr}, 16'h0000);
      chk({3'h0, sp_count}, 16'h0346);
      set_unit(3'h6);
      chk({13'h0, unit_act}, 16'h0004);
      chk({15'h0, nv_wr}, 16'h0000);
      // Every engineering unit at full scale, lowest range
      for (u = 1; u <= 5; u++) begin
         set_unit(u[2:0]);
         plc.send(fs01[u]);
         wt(3);
         chk({3'h0, sp_count}, 16'h0FFF);
         chk(fb_word, fs01[u]);
      end
      // Other body ranges and over-range in units
      set_unit(U_PSI);
      drive(13'h0FFF, B_05);
      plc.send(`PSW_FS_B05_PSI);
      wt(3);
      chk({3'h0, sp_count}, 16'h0FFF);
      chk(fb_word, `PSW_FS_B05_PSI);
      set_unit(U_KPA);
      drive(13'h0FFF, B_09);
      plc.send(`PSW_FS_B09_KPA);
      wt(3);
      chk(fb_word, `PSW_FS_B09_KPA);
      drive(13'h1332, B_01);
      plc.send(16'h2EE0);
      wt(3);
      chk({3'h0, sp_count}, 16'h1332);
      chk(fb_word, 16'h2EE0);
      plc.send(16'h32C8);
      wt(3);
      chk({3'h0, sp_count}, 16'h1332);
      // Restore of the stored unit
      restore(3'h3, 1'b1);
      chk({13'h0, unit_act}, 16'h0003);
      restore(3'h7, 1'b1);
      chk({13'h0, unit_act}, 16'h0003);
      // Window diagnostic, counts
      set_unit(U_CNT);
      plc.send(16'h0800);
      drive(13'h0857, B_01);
      wt(3);
      chk({15'h0, win_fault}, 16'h0000);
      drive(13'h0858, B_01);
      expect_fault(440, 120);
      drive(13'h0857, B_01);
      wt(2);
      chk({15'h0, win_fault}, 16'h0000);
      set_gs(4'hF, 3'h2);
      drive(13'h0858, B_01);
      expect_fault(80, 40);
      drive(13'h0800, B_01);
      set_gs(4'h0, 3'h2);
      wt(3);
      drive(13'h0858, B_01);
      expect_fault(880, 150);
      set_gs(4'hF, 3'h0);
      drive(13'h0829, B_01);
      wt(3);
      chk({15'h0, win_fault}, 16'h0001);
      set_gs(4'hF, 3'h7);
      drive(13'h08CC, B_01);
      wt(3);
      chk({15'h0, win_fault}, 16'h0000);
      drive(13'h08CD, B_01);
      expect_fault(80, 40);
      conclude();
   end
endmodule // pswin_top_tb
